// ### common/gpp_pkg.sv
/*
 * Constants shared by the general-purpose port block (ports 6, 7, 8):
 * register offsets, reset values, bus answers and the address match.
 * Assumes a 32-bit AXI4-Lite bus with 12 address bits.
 */
package gpp_pkg;

    // Pins per port and bus address width
    localparam int GPP_PINS = 8;
    localparam int GPP_AW   = 12;

    // Register byte offsets
    localparam logic [11:0] GPP_OFF_DATA6 = 12'h000;
    localparam logic [11:0] GPP_OFF_DIR6  = 12'h004;
    localparam logic [11:0] GPP_OFF_PU6   = 12'h008;
    localparam logic [11:0] GPP_OFF_DATA7 = 12'h00C;
    localparam logic [11:0] GPP_OFF_DIR7  = 12'h010;
    localparam logic [11:0] GPP_OFF_DATA8 = 12'h014;
    localparam logic [11:0] GPP_OFF_DIR8  = 12'h018;
    localparam logic [11:0] GPP_OFF_FUNC  = 12'h01C;

    // Values after reset and fixed read values
    localparam logic [7:0]  GPP_DATA_RST = 8'h00;
    localparam logic [7:0]  GPP_DIR_RST  = 8'h00;
    localparam logic [7:0]  GPP_PU_RST   = 8'h00;
    localparam logic [23:0] GPP_FUNC_RST = 24'hFF_FFFF;
    localparam logic [7:0]  GPP_DIR_READ = 8'hFF;
    localparam logic [2:0]  GPP_SYNC_RST = 3'h0;

    // Bus answers
    localparam logic [1:0] GPP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPP_RESP_DECERR = 2'h3;

    // Word match of a byte address against a register offset
    function automatic logic gpp_hit(input logic [11:0] addr,
                                     input logic [11:0] off);
        gpp_hit = (addr[11:2] == off[11:2]);
    endfunction : gpp_hit

endpackage : gpp_pkg

// ### common/gpp_port_if.sv
/*
 * Bundle between the register core and one port's pin logic.
 * Assumes the core drives the settings and the port answers.
 */
`timescale 1ns/10ps
interface gpp_port_if;
    logic [7:0] latch;   // Data latch
    logic [7:0] dir;     // 1 output, 0 input
    logic [7:0] func;    // 1 pin is general purpose
    logic [7:0] pu;      // Pull-up enable bits
    logic [7:0] lvl;     // Synchronised pin level
    logic [7:0] rd_val;  // Value a data read returns
    logic [7:0] pin_o;   // Pin drive value
    logic [7:0] oe_n;    // Low while the pin is driven
    logic [7:0] pu_on;   // Pull-up switched on

    modport core (output latch, dir, func, pu, lvl,
                  input  rd_val, pin_o, oe_n, pu_on);
    modport port (input  latch, dir, func, pu, lvl,
                  output rd_val, pin_o, oe_n, pu_on);
endinterface : gpp_port_if

// ### src/gpp_sync.sv
/*
 * Three-stage pin synchroniser: a new level is taken once the
 * second and third stages agree. Assumes pins are asynchronous.
 */
`timescale 1ns/10ps
module gpp_sync
    import gpp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [23:0] pins,
    output      logic [23:0] lvl_q
);
    logic [23:0] s1_q;
    logic [23:0] s2_q;
    logic [23:0] s3_q;
    logic [23:0] agree;
    logic [23:0] lvl_d;

    // Take the third stage only where it matches the second
    assign agree = s2_q ~^ s3_q;
    assign lvl_d = (s3_q & agree) | (lvl_q & ~agree);

    // Stage chain, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= {8{GPP_SYNC_RST}};
            s2_q  <= {8{GPP_SYNC_RST}};
            s3_q  <= {8{GPP_SYNC_RST}};
            lvl_q <= {8{GPP_SYNC_RST}};
        end else if (ce) begin
            s1_q  <= pins;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end
endmodule : gpp_sync

// ### src/gpp_port.sv
/*
 * Pin logic of one 8-bit port: drive, enable, pull-up, read value.
 * Assumes settings come from flip-flops in the register core.
 */
`timescale 1ns/10ps
module gpp_port
    import gpp_pkg::*;
(
    gpp_port_if.port gp
);
    logic [7:0] gpio_out;

    // Output only where the bit is 1 and the pin is general purpose
    assign gpio_out = gp.dir & gp.func;
    assign gp.oe_n  = ~gpio_out;
    assign gp.pin_o = gp.latch & gpio_out;

    // Pull-up only on a general-purpose input with its bit set
    assign gp.pu_on = gp.pu & ~gp.dir & gp.func;

    // Output bits read the latch, input bits the pin
    assign gp.rd_val = (gp.latch & gp.dir)
                     | (gp.lvl & ~gp.dir);
endmodule : gpp_port

// ### src/gpp_top.sv
/*
 * General-purpose I/O ports 6, 7 and 8 behind an AXI4-Lite slave:
 * data latches, write-only direction bits, port 6 pull-ups and a
 * function-select word that hands pins to other functions.
 * Assumes one clock, synchronous reset and asynchronous pin inputs.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - A port 6 general-purpose input pin has its pull-up on exactly when its enable bit is 1.
// - After reset every pull-up is off.
// - The pull-up register holds eight bits, bit n for port 6 pin n.
// - A direction bit of 1 makes its own pin an output, 0 an input.
// - Direction registers are write-only and read back as all ones.
// - Data reads return the latch for bits whose direction is output.
// - Data reads return the sampled pin level for input bits.
// - Direction and latch act only while the pin is general purpose.
// - Port 8 has an eight-bit direction register of the same form.
module gpp_top
    import gpp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  p6_in,
    output      logic [7:0]  p6_out,
    output      logic [7:0]  p6_oe_n,
    output      logic [7:0]  p6_pullup,
    input  wire logic [7:0]  p7_in,
    output      logic [7:0]  p7_out,
    output      logic [7:0]  p7_oe_n,
    input  wire logic [7:0]  p8_in,
    output      logic [7:0]  p8_out,
    output      logic [7:0]  p8_oe_n
);

    // Registers seen by software
    logic [7:0]  data_latch_port6_q;
    logic [7:0]  data_latch_port7_q;
    logic [7:0]  data_latch_port8_q;
    logic [7:0]  direction_port6_q;
    logic [7:0]  direction_port7_q;
    logic [7:0]  direction_port8_q;
    logic [7:0]  pullup_enable_port6_q;
    logic [23:0] func_sel_q;

    // Write channel state
    logic        aw_got_q;
    logic [11:0] awaddr_q;
    logic        w_got_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;

    // Read channel state
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // Decode and handshake wires
    logic        wr_go;
    logic        wr_lane0;
    logic        wr_known;
    logic        we_data6;
    logic        we_dir6;
    logic        we_pu6;
    logic        we_data7;
    logic        we_dir7;
    logic        we_data8;
    logic        we_dir8;
    logic        we_func;
    logic        rd_take;
    logic        rd_known;
    logic [7:0]  rd_byte;
    logic [31:0] rd_word;
    logic [23:0] pin_lvl;

    gpp_port_if p6_if ();
    gpp_port_if p7_if ();
    gpp_port_if p8_if ();

    // Bus handshakes; ce low holds every ready low
    assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
    assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rd_take       = s_axi_arvalid & s_axi_arready;

    // A write runs once address and data are both held
    assign wr_go    = ce & aw_got_q & w_got_q & ~bvalid_q;
    assign wr_lane0 = wr_go & wstrb_q[0];

    // Write decode
    assign we_data6 = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DATA6);
    assign we_dir6  = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DIR6);
    assign we_pu6   = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_PU6);
    assign we_data7 = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DATA7);
    assign we_dir7  = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DIR7);
    assign we_data8 = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DATA8);
    assign we_dir8  = wr_lane0 & gpp_hit(awaddr_q, GPP_OFF_DIR8);
    assign we_func  = wr_go & gpp_hit(awaddr_q, GPP_OFF_FUNC);

    // Offsets that answer OKAY
    assign wr_known = gpp_hit(awaddr_q, GPP_OFF_DATA6)
                    | gpp_hit(awaddr_q, GPP_OFF_DIR6)
                    | gpp_hit(awaddr_q, GPP_OFF_PU6)
                    | gpp_hit(awaddr_q, GPP_OFF_DATA7)
                    | gpp_hit(awaddr_q, GPP_OFF_DIR7)
                    | gpp_hit(awaddr_q, GPP_OFF_DATA8)
                    | gpp_hit(awaddr_q, GPP_OFF_DIR8)
                    | gpp_hit(awaddr_q, GPP_OFF_FUNC);

    // Read selection; direction words always read as ones
    assign rd_byte =
        gpp_hit(s_axi_araddr, GPP_OFF_DATA6) ? p6_if.rd_val :
        gpp_hit(s_axi_araddr, GPP_OFF_DATA7) ? p7_if.rd_val :
        gpp_hit(s_axi_araddr, GPP_OFF_DATA8) ? p8_if.rd_val :
        gpp_hit(s_axi_araddr, GPP_OFF_PU6)
            ? pullup_enable_port6_q :
        gpp_hit(s_axi_araddr, GPP_OFF_DIR6) ? GPP_DIR_READ :
        gpp_hit(s_axi_araddr, GPP_OFF_DIR7) ? GPP_DIR_READ :
        gpp_hit(s_axi_araddr, GPP_OFF_DIR8) ? GPP_DIR_READ :
        8'h00;
    assign rd_known = gpp_hit(s_axi_araddr, GPP_OFF_DATA6)
                    | gpp_hit(s_axi_araddr, GPP_OFF_DIR6)
                    | gpp_hit(s_axi_araddr, GPP_OFF_PU6)
                    | gpp_hit(s_axi_araddr, GPP_OFF_DATA7)
                    | gpp_hit(s_axi_araddr, GPP_OFF_DIR7)
                    | gpp_hit(s_axi_araddr, GPP_OFF_DATA8)
                    | gpp_hit(s_axi_araddr, GPP_OFF_DIR8)
                    | gpp_hit(s_axi_araddr, GPP_OFF_FUNC);
    assign rd_word =
        gpp_hit(s_axi_araddr, GPP_OFF_FUNC) ? {8'h00, func_sel_q}
                                            : {24'h00_0000, rd_byte};

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= GPP_RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_known ? GPP_RESP_OKAY : GPP_RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= GPP_RESP_OKAY;
        end else if (ce) begin
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_known ? rd_word : 32'h0000_0000;
                rresp_q  <= rd_known ? GPP_RESP_OKAY : GPP_RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Data latches take every bit, whatever the directions
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_latch_port6_q <= GPP_DATA_RST;
            data_latch_port7_q <= GPP_DATA_RST;
            data_latch_port8_q <= GPP_DATA_RST;
        end else begin
            if (we_data6) data_latch_port6_q <= wdata_q[7:0];
            if (we_data7) data_latch_port7_q <= wdata_q[7:0];
            if (we_data8) data_latch_port8_q <= wdata_q[7:0];
        end
    end

    // Direction registers, write only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direction_port6_q <= GPP_DIR_RST;
            direction_port7_q <= GPP_DIR_RST;
            direction_port8_q <= GPP_DIR_RST;
        end else begin
            if (we_dir6) direction_port6_q <= wdata_q[7:0];
            if (we_dir7) direction_port7_q <= wdata_q[7:0];
            if (we_dir8) direction_port8_q <= wdata_q[7:0];
        end
    end

    // Pull-up enables off after reset; function select per byte lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pullup_enable_port6_q <= GPP_PU_RST;
            func_sel_q            <= GPP_FUNC_RST;
        end else begin
            if (we_pu6) pullup_enable_port6_q <= wdata_q[7:0];
            if (we_func && wstrb_q[0]) func_sel_q[7:0]   <= wdata_q[7:0];
            if (we_func && wstrb_q[1]) func_sel_q[15:8]  <= wdata_q[15:8];
            if (we_func && wstrb_q[2]) func_sel_q[23:16] <= wdata_q[23:16];
        end
    end

    // Pin levels through the synchroniser
    gpp_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pins    ({p8_in, p7_in, p6_in}),
        .lvl_q   (pin_lvl)
    );

    // Settings into each port bundle
    assign p6_if.latch = data_latch_port6_q;
    assign p6_if.dir   = direction_port6_q;
    assign p6_if.func  = func_sel_q[7:0];
    assign p6_if.pu    = pullup_enable_port6_q;
    assign p6_if.lvl   = pin_lvl[7:0];
    assign p7_if.latch = data_latch_port7_q;
    assign p7_if.dir   = direction_port7_q;
    assign p7_if.func  = func_sel_q[15:8];
    assign p7_if.pu    = 8'h00;
    assign p7_if.lvl   = pin_lvl[15:8];
    assign p8_if.latch = data_latch_port8_q;
    assign p8_if.dir   = direction_port8_q;
    assign p8_if.func  = func_sel_q[23:16];
    assign p8_if.pu    = 8'h00;
    assign p8_if.lvl   = pin_lvl[23:16];

    gpp_port u_port6 (.gp (p6_if.port));
    gpp_port u_port7 (.gp (p7_if.port));
    gpp_port u_port8 (.gp (p8_if.port));

    // Pin outputs
    assign p6_out    = p6_if.pin_o;
    assign p6_oe_n   = p6_if.oe_n;
    assign p6_pullup = p6_if.pu_on;
    assign p7_out    = p7_if.pin_o;
    assign p7_oe_n   = p7_if.oe_n;
    assign p8_out    = p8_if.pin_o;
    assign p8_oe_n   = p8_if.oe_n;

    // Checks on pins and register behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pullup_input_only_a:
        assert property ((p6_pullup & ~p6_oe_n) == 8'h00)
        else $error("pull-up on while pin driven");

    pullup_from_bit_a:
        assert property (((p6_pullup ^ pullup_enable_port6_q)
                          & p6_oe_n & func_sel_q[7:0]) == 8'h00)
        else $error("pull-up differs from its enable bit");

    pullup_reset_off_a:
        assert property (disable iff (1'b0)
                         !aresetn |=> p6_pullup == 8'h00)
        else $error("pull-up on after reset");

    dir_reads_ones_a:
        assert property (rd_take
            && gpp_hit(s_axi_araddr, GPP_OFF_DIR7)
            |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00FF)
        else $error("direction read not all ones");

    read_out_latch_a:
        assert property (rd_take
            && gpp_hit(s_axi_araddr, GPP_OFF_DATA6)
            |=> ((s_axi_rdata[7:0] ^ $past(data_latch_port6_q))
                 & $past(direction_port6_q)) == 8'h00)
        else $error("output bit did not read the latch");

    read_in_pin_a:
        assert property (rd_take
            && gpp_hit(s_axi_araddr, GPP_OFF_DATA7)
            |=> ((s_axi_rdata[7:0] ^ $past(pin_lvl[15:8]))
                 & ~$past(direction_port7_q)) == 8'h00)
        else $error("input bit did not read the pin");

    dir_write_drive_a:
        assert property (we_dir7
            |=> ~p7_oe_n == ($past(wdata_q[7:0]) & func_sel_q[15:8]))
        else $error("port 7 direction write not applied");

    dir8_write_drive_a:
        assert property (we_dir8
            |=> ~p8_oe_n == ($past(wdata_q[7:0]) & func_sel_q[23:16]))
        else $error("port 8 direction write not applied");

    drive_from_latch_a:
        assert property (((p6_out ^ data_latch_port6_q) & ~p6_oe_n)
                         == 8'h00)
        else $error("driven pin differs from its latch");

    latch_all_bits_a:
        assert property (we_data8
            |=> data_latch_port8_q == $past(wdata_q[7:0]))
        else $error("data write did not take all bits");

    func_gates_pin_a:
        assert property ((~func_sel_q[15:8] & ~p7_oe_n) == 8'h00)
        else $error("pin driven outside its gpio function");

endmodule : gpp_top

// ### test/gpp_board.sv
/*
 * Board model for one 8-bit port: works out the level of each pin.
 * Assumes the device drives a pin only while its enable is low.
 */
`timescale 1ns/10ps
module gpp_board (
    input  wire logic       aclk,
    input  wire logic [7:0] dev_out,
    input  wire logic [7:0] dev_oe_n,
    input  wire logic [7:0] dev_pu,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output      logic [7:0] pin
);
    logic [7:0] last_q;

    // Last level, so an undriven pin keeps wandering
    always_ff @(posedge aclk) begin
        last_q <= pin;
    end

    // Device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!dev_oe_n[i]) begin
                pin[i] = dev_out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (dev_pu[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = ~last_q[i];  // Floating: never a stable level
            end
        end
    end
endmodule : gpp_board

// ### test/tb_gpio_ports_pullup_dir.sv
/*
 * Self-checking bench for the port 6/7/8 block over AXI4-Lite.
 * Assumes the pin synchroniser settles within six clock cycles.
 */
`timescale 1ns/10ps
module tb_gpio_ports_pullup_dir
    import gpp_pkg::*;
;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] p6_in, p6_out, p6_oe_n, p6_pullup, p7_in, p7_out;
    logic [7:0] p7_oe_n, p8_in, p8_out, p8_oe_n;
    logic [7:0] ext_val [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] ext_en [3] = '{8'hFF, 8'hFF, 8'hFF};
    logic [11:0] data_off [3] = '{GPP_OFF_DATA6, GPP_OFF_DATA7,
                                  GPP_OFF_DATA8};
    logic [11:0] dir_off [3] = '{GPP_OFF_DIR6, GPP_OFF_DIR7, GPP_OFF_DIR8};
    int err_total = 0, total_checks = 0;
    logic [31:0] rd_d;
    logic [1:0] rsp;
    logic [3:0] wr_strb = 4'hF;

    always #4 aclk = ~aclk;

    gpp_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p6_in, .p6_out,
        .p6_oe_n, .p6_pullup, .p7_in, .p7_out, .p7_oe_n, .p8_in,
        .p8_out, .p8_oe_n);
    gpp_board b6 (.aclk, .dev_out(p6_out), .dev_oe_n(p6_oe_n),
        .dev_pu(p6_pullup), .ext_val(ext_val[0]), .ext_en(ext_en[0]),
        .pin(p6_in));
    gpp_board b7 (.aclk, .dev_out(p7_out), .dev_oe_n(p7_oe_n),
        .dev_pu(8'h00), .ext_val(ext_val[1]), .ext_en(ext_en[1]),
        .pin(p7_in));
    gpp_board b8 (.aclk, .dev_out(p8_out), .dev_oe_n(p8_oe_n),
        .dev_pu(8'h00), .ext_val(ext_val[2]), .ext_en(ext_en[2]),
        .pin(p8_in));

    // One comparison, counted and reported at once
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // Write cycle; handshakes judged at the falling edge before each rise
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_hs, w_hs, b_hs, done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wstrb <= wr_strb;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!done) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid & s_axi_awready;
            w_hs = s_axi_wvalid & s_axi_wready;
            b_hs = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 0;
            if (w_hs) s_axi_wvalid <= 0;
            if (b_hs) s_axi_bready <= 0;
            done = b_hs;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar_hs, r_hs;
        r_hs = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid & s_axi_arready;
            r_hs = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 0;
            if (r_hs) s_axi_rready <= 0;
        end
    endtask : rd

    // Values straight after reset
    task automatic tst_reset;
        for (int k = 0; k < 3; k++) begin
            rd(dir_off[k], rd_d, rsp);
            chk("dir read", 32'h0000_00FF, rd_d);
            rd(data_off[k], rd_d, rsp);
            chk("data read", 32'h0000_0000, rd_d);
        end
        rd(GPP_OFF_PU6, rd_d, rsp);
        chk("pullup reg", 32'h0000_0000, rd_d);
        chk("p6_pullup", 32'h0000_0000, {24'h0, p6_pullup});
        chk("p7_oe_n", 32'h0000_00FF, {24'h0, p7_oe_n});
        $display("test reset done");
    endtask : tst_reset

    // Mixed directions on one port: drive, read mux, latch update
    task automatic tst_port(input int k);
        logic [7:0] oe, po;
        ext_val[k] <= 8'h3C;
        wr(data_off[k], 32'h0000_00A5, rsp);
        wr(dir_off[k], 32'h0000_000F, rsp);
        repeat (6) @(posedge aclk);
        oe = (k == 0) ? p6_oe_n : (k == 1) ? p7_oe_n : p8_oe_n;
        po = (k == 0) ? p6_out : (k == 1) ? p7_out : p8_out;
        chk("oe_n", 32'h0000_00F0, {24'h0, oe});
        chk("out", 32'h0000_0005, {24'h0, po});
        rd(data_off[k], rd_d, rsp);
        chk("data mux", 32'h0000_0035, rd_d);
        rd(dir_off[k], rd_d, rsp);
        chk("dir read", 32'h0000_00FF, rd_d);
        wr(data_off[k], 32'h0000_005A, rsp);
        wr(dir_off[k], 32'h0000_00FF, rsp);
        po = (k == 0) ? p6_out : (k == 1) ? p7_out : p8_out;
        chk("out all", 32'h0000_005A, {24'h0, po});
        wr(dir_off[k], 32'h0000_0000, rsp);
        $display("test port %0d done", k);
    endtask : tst_port

    // Pull-ups act on input pins only
    task automatic tst_pullup;
        wr(GPP_OFF_DIR6, 32'h0000_00F0, rsp);
        wr(GPP_OFF_PU6, 32'h0000_003C, rsp);
        chk("p6_pullup", 32'h0000_000C, {24'h0, p6_pullup});
        rd(GPP_OFF_PU6, rd_d, rsp);
        chk("pullup reg", 32'h0000_003C, rd_d);
        ext_en[0] <= 8'h00;
        repeat (6) @(posedge aclk);
        rd(GPP_OFF_DATA6, rd_d, rsp);
        chk("pulled data", 32'h0000_005C, rd_d & 32'h0000_00FC);
        wr(GPP_OFF_DIR6, 32'h0000_00FF, rsp);
        wr(GPP_OFF_PU6, 32'h0000_00FF, rsp);
        chk("pu on out", 32'h0000_0000, {24'h0, p6_pullup});
        wr(GPP_OFF_DIR6, 32'h0000_0000, rsp);
        wr(GPP_OFF_PU6, 32'h0000_0000, rsp);
        ext_en[0] <= 8'hFF;
        $display("test pullup done");
    endtask : tst_pullup

    // Port 7 handed to another function and back
    task automatic tst_func;
        wr(GPP_OFF_DATA7, 32'h0000_00FF, rsp);
        wr(GPP_OFF_DIR7, 32'h0000_00FF, rsp);
        wr(GPP_OFF_FUNC, 32'h00FF_00FF, rsp);
        chk("oe_n other fn", 32'h0000_00FF, {24'h0, p7_oe_n});
        chk("out other fn", 32'h0000_0000, {24'h0, p7_out});
        wr(GPP_OFF_FUNC, 32'h00FF_FFFF, rsp);
        chk("oe_n gpio", 32'h0000_0000, {24'h0, p7_oe_n});
        wr(GPP_OFF_DIR7, 32'h0000_0000, rsp);
        $display("test func done");
    endtask : tst_func

    // Unmapped place and a read held off by a low clock enable
    task automatic tst_bus;
        wr(12'h020, 32'h0000_00FF, rsp);
        chk("wr resp", {30'h0, GPP_RESP_DECERR}, {30'h0, rsp});
        rd(12'h020, rd_d, rsp);
        chk("rd resp", {30'h0, GPP_RESP_DECERR}, {30'h0, rsp});
        chk("rd unmapped", 32'h0000_0000, rd_d);
        @(posedge aclk);
        ce <= 0;
        fork
            rd(GPP_OFF_DIR7, rd_d, rsp);
            begin
                repeat (4) begin
                    @(negedge aclk);
                    chk("arready ce low", 32'h0, {31'h0, s_axi_arready});
                end
                @(posedge aclk);
                ce <= 1;
            end
        join
        chk("dir after ce", 32'h0000_00FF, rd_d);
        $display("test bus done");
    endtask : tst_bus

    // Write with byte lane 0 off leaves an 8-bit register alone
    task automatic tst_strb;
        wr_strb = 4'hE;
        wr(GPP_OFF_DIR7, 32'h0000_00FF, rsp);
        wr_strb = 4'hF;
        chk("dir lane off", 32'h0000_00FF, {24'h0, p7_oe_n});
        $display("test strobe done");
    endtask : tst_strb

    // Reset in mid-run clears pull-ups that were on
    task automatic tst_rst2;
        wr(GPP_OFF_PU6, 32'h0000_00FF, rsp);
        chk("pu before rst", 32'h0000_00FF, {24'h0, p6_pullup});
        @(posedge aclk);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (6) @(posedge aclk);
        chk("pu after rst", 32'h0000_0000, {24'h0, p6_pullup});
        rd(GPP_OFF_PU6, rd_d, rsp);
        chk("pullup reg rst", 32'h0000_0000, rd_d);
        $display("test reset again done");
    endtask : tst_rst2

    // Watchdog on the whole run
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (6) @(posedge aclk);
        tst_reset();
        for (int k = 0; k < 3; k++) tst_port(k);
        tst_pullup();
        tst_func();
        tst_bus();
        tst_strb();
        tst_rst2();
        end_of_test();
    end
endmodule : tb_gpio_ports_pullup_dir
